//--- verilog/quad_switch_protect_ctrl.sv
module quad_switch_protect_ctrl #(
	parameter longint INRUSH_CYC = qsw_pkg::INRUSH_CYC,
	parameter longint RETRY_CYC  = qsw_pkg::RETRY_CYC
) (
	input  wire logic                 ref_clk,
	input  wire logic                 arst_n,
	input  wire logic                 ce,
	input  wire logic [3:0]           ctrl_in,
	input  wire logic                 hold_select,
	input  wire logic                 global_disable_n,
	input  wire logic                 inrush_enable,
	input  wire qsw_pkg::supervision_t flags,
	input  wire logic [3:0]           addr,
	input  wire logic [31:0]          wdata,
	input  wire logic                 wr_stb,
	input  wire logic                 rd_stb,
	output logic      [31:0]          rdata,
	output logic      [3:0]           switch_on,
	output logic                      limit_default,
	output logic                      limit_double,
	output logic                      regulator_enable,
	output logic                      fault_o,
	output logic                      fault_oe_n,
	output logic                      reverse_flow_n_o,
	output logic                      reverse_flow_n_oe_n
);

	// ------------------------------------------------------------
	// Configuration checks
	// ------------------------------------------------------------
	if (INRUSH_CYC < 64'd1 || INRUSH_CYC > 64'hffff_ffff) begin : g_bad_inrush
		$error("inrush window count out of range");
	end
	if (RETRY_CYC < 64'd1 || RETRY_CYC > 64'hffff_ffff) begin : g_bad_retry
		$error("retry period count out of range");
	end
	// The disable path must meet its turn-off bound.
	if (qsw_pkg::PIN_LAT_CYC > qsw_pkg::DIS_MAX_CYC) begin : g_bad_dis
		$error("disable latency exceeds its bound");
	end

	// ------------------------------------------------------------
	// Pin synchronisation
	// ------------------------------------------------------------
	qsw_pkg::pins_t pins;
	qsw_pkg::pins_t s;

	// One driver for the whole carrier, in the field order of pins_t.
	assign pins = {ctrl_in, hold_select, global_disable_n, inrush_enable, flags};

	// Controls and flags share one synchroniser, so a hold edge and a
	// control change reach the command register with equal delay.
	// equal path delay
	pin_sync3 #(
		.W   ($bits(qsw_pkg::pins_t)),
		.RST (qsw_pkg::PINS_RESET)
	) u_sync (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.ce      (ce),
		.pin     (pins),
		.sync    (s)
	);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	logic [3:0]  cmd_r;
	logic [3:0]  cmd_nxt;
	logic [3:0]  switch_on_r;
	logic [3:0]  on_nxt;
	logic [31:0] ctrl_r;
	logic        fault_r;
	logic        fault_nxt;
	logic        pwrup_r;
	logic        rev_hold_r;
	logic        lim_def_r;
	logic        dbl_r;
	logic        regen_r;
	logic [31:0] rdata_r;

	// ------------------------------------------------------------
	// Protection decode
	// ------------------------------------------------------------
	logic       uv_any;
	logic       die_sd;
	logic       rev_any;
	logic       rev_busy;
	logic       rev_block;
	logic       allow;
	logic       inrush_busy;
	logic       inrush_go;
	logic [3:0] ch_fault;
	logic       soft_off;

	assign soft_off = ctrl_r[qsw_pkg::CTRL_SOFT_OFF];
	assign uv_any = s.sup.uv_field | s.sup.uv_5v | s.sup.uv_logic;
	// die shutdown, monitored only with 5V good
	assign die_sd = s.sup.die_ot & ~s.sup.uv_5v;
	assign rev_any = |s.sup.reverse_flow_n;
	// reverse hold, starting in the detect cycle
	assign rev_block = rev_any | rev_busy;

	// Every global protection term except reg_ot and lim_open gates all four switches at once.
	// switch gating
	assign allow = s.dis_n & ~uv_any & ~die_sd & ~s.sup.lim_short & ~rev_block
	               & ~soft_off;
	// restore on enable
	// The next command feeds the switch directly, so a control change costs
	// the same one output flop as the global protection terms.
	assign on_nxt = cmd_nxt & ~s.sup.chan_ot & {4{allow}};

	// Channel faults only count on commanded channels.
	// commanded channels only
	assign ch_fault = cmd_r & (s.sup.chan_ot | s.sup.reverse_flow_n);

	assign fault_nxt = pwrup_r | die_sd | s.sup.uv_5v | s.sup.lim_short
	                   | s.sup.reg_ot | (|ch_fault);

	// Command register: transparent with hold low, frozen with hold high.
	// hold freezes
	assign cmd_nxt = s.hold ? cmd_r : s.ctrl;

	// ------------------------------------------------------------
	// Timers
	// ------------------------------------------------------------
	// inrush start on turn-on
	assign inrush_go = s.inrush_en & (|(on_nxt & ~switch_on_r));

	down_timer #(
		.W    (32),
		.LOAD (INRUSH_CYC[31:0])
	) u_inrush (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.ce      (ce),
		.start   (inrush_go),
		.busy    (inrush_busy)
	);

	// A fresh detection while counting restarts the full retry period.
	// retry period
	down_timer #(
		.W    (32),
		.LOAD (RETRY_CYC[31:0])
	) u_retry (
		.ref_clk (ref_clk),
		.arst_n  (arst_n),
		.ce      (ce),
		.start   (rev_any),
		.busy    (rev_busy)
	);

	// ------------------------------------------------------------
	// Switch and status flops
	// ------------------------------------------------------------
	// Fault starts asserted and the power-up hold clears only once.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cmd_r       <= 4'h0;
			switch_on_r <= 4'h0;
			fault_r     <= 1'b1;
			pwrup_r     <= 1'b1;
			rev_hold_r  <= 1'b0;
			lim_def_r   <= 1'b1;
			dbl_r       <= 1'b0;
			regen_r     <= 1'b0;
		end else if (ce) begin
			cmd_r       <= cmd_nxt;
			switch_on_r <= on_nxt;
			fault_r     <= fault_nxt;
			pwrup_r     <= pwrup_r & s.sup.uv_5v;
			rev_hold_r  <= rev_block;
			lim_def_r   <= s.sup.lim_open;
			dbl_r       <= inrush_busy & s.inrush_en;
			regen_r     <= ~s.sup.reg_ot;
		end
	end

	assign switch_on        = switch_on_r;
	assign limit_default    = lim_def_r;
	assign limit_double     = dbl_r;
	assign regulator_enable = regen_r;
	// Open-drain pins: low level, enable active low while pulling.
	assign fault_o             = 1'b0;
	assign fault_oe_n          = ~fault_r;
	assign reverse_flow_n_o    = 1'b0;
	assign reverse_flow_n_oe_n = ~rev_hold_r;

	// ------------------------------------------------------------
	// Register port
	// ------------------------------------------------------------
	logic        wr_ctrl;
	logic [31:0] status;
	logic [31:0] rd_mux;

	assign wr_ctrl = wr_stb & (addr == qsw_pkg::ADDR_CTRL);

	// Status mirrors the block's own state for software.
	always_comb begin
		status = 32'h0;
		status[qsw_pkg::ST_SW_LSB +: 4]   = switch_on_r;
		status[qsw_pkg::ST_CMD_LSB +: 4]  = cmd_r;
		status[qsw_pkg::ST_FAULT]         = fault_r;
		status[qsw_pkg::ST_REV]           = rev_hold_r;
		status[qsw_pkg::ST_INRUSH]        = dbl_r;
		status[qsw_pkg::ST_DIE]           = die_sd;
		status[qsw_pkg::ST_LIMDEF]        = lim_def_r;
		status[qsw_pkg::ST_PWRUP]         = pwrup_r;
		status[qsw_pkg::ST_REGEN]         = regen_r;
		status[qsw_pkg::ST_CHOT_LSB +: 4] = s.sup.chan_ot;
	end

	// Unmapped addresses read as zero.
	assign rd_mux = (addr == qsw_pkg::ADDR_STATUS) ? status :
	                (addr == qsw_pkg::ADDR_CTRL)   ? ctrl_r : 32'h0;

	// Read data stands only in the cycle after the strobe.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			ctrl_r  <= qsw_pkg::CTRL_RESET;
			rdata_r <= 32'h0;
		end else if (ce) begin
			if (wr_ctrl) begin
				ctrl_r <= {31'h0, wdata[qsw_pkg::CTRL_SOFT_OFF]};
			end
			rdata_r <= rd_stb ? rd_mux : 32'h0;
		end
	end

	assign rdata = rdata_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	property p_uv_off;
		(ce && uv_any) |=> (switch_on_r == 4'h0);
	endproperty
	a_uv_off: assert property (p_uv_off)
		else $error("switch on during undervoltage");

	property p_lim_default;
		(ce && s.sup.lim_open) |=> limit_default;
	endproperty
	a_lim_default: assert property (p_lim_default)
		else $error("default limit not selected");

	property p_short_off;
		(ce && s.sup.lim_short) |=> (switch_on_r == 4'h0) && !fault_oe_n;
	endproperty
	a_short_off: assert property (p_short_off)
		else $error("limit short did not force off");

	property p_fault_clear;
		(ce && !fault_oe_n) ##1 (ce && !fault_nxt) |=> fault_oe_n;
	endproperty
	a_fault_clear: assert property (p_fault_clear)
		else $error("fault not released");

	property p_pwrup;
		pwrup_r |-> !fault_oe_n;
	endproperty
	a_pwrup: assert property (p_pwrup)
		else $error("fault released before 5V good");

	property p_ch_fault;
		(ce && (|(cmd_r & s.sup.chan_ot))) |=> !fault_oe_n;
	endproperty
	a_ch_fault: assert property (p_ch_fault)
		else $error("channel fault not flagged");

	property p_die;
		(ce && die_sd) |=> (switch_on_r == 4'h0) && !fault_oe_n;
	endproperty
	a_die: assert property (p_die)
		else $error("die shutdown not applied");

	property p_chan;
		(ce && s.sup.chan_ot[0]) |=> !switch_on_r[0];
	endproperty
	a_chan: assert property (p_chan)
		else $error("hot channel left on");

	property p_reg;
		(ce && s.sup.reg_ot) |=> !regulator_enable;
	endproperty
	a_reg: assert property (p_reg)
		else $error("regulator enabled while hot");

	property p_dis;
		(ce && !global_disable_n)[*6] |=> (switch_on_r == 4'h0);
	endproperty
	a_dis: assert property (p_dis)
		else $error("disable did not turn switches off in time");

	property p_hold;
		(ce && s.hold) |=> $stable(cmd_r);
	endproperty
	a_hold: assert property (p_hold)
		else $error("command changed while held");

	property p_no_inrush;
		(ce && !s.inrush_en) |=> !limit_double;
	endproperty
	a_no_inrush: assert property (p_no_inrush)
		else $error("doubled limit with inrush disabled");

	property p_rev;
		(ce && rev_any) |=> !reverse_flow_n_oe_n && (switch_on_r == 4'h0);
	endproperty
	a_rev: assert property (p_rev)
		else $error("reverse current not acted on");

endmodule : quad_switch_protect_ctrl

//--- include/qsw_pkg.sv
package qsw_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam longint CLK_PERIOD_NS  = 64'd8;
	localparam longint INRUSH_TIME_NS = 64'd12_500_000;
	localparam longint RETRY_TIME_MS  = 64'd2000;
	localparam longint DIS_MAX_NS     = 64'd100;
	// A least time rounds up, a longest time rounds down.
	localparam longint INRUSH_CYC = (INRUSH_TIME_NS + CLK_PERIOD_NS - 64'd1) / CLK_PERIOD_NS;
	localparam longint RETRY_CYC  = (RETRY_TIME_MS * 64'd1_000_000) / CLK_PERIOD_NS;
	localparam longint DIS_MAX_CYC = DIS_MAX_NS / CLK_PERIOD_NS;
	// Pin to switch latency: three sync stages, agreement stage, output flop.
	localparam longint PIN_LAT_CYC = 64'd5;

	// ------------------------------------------------------------
	// Register map
	// ------------------------------------------------------------
	localparam logic [3:0]  ADDR_STATUS  = 4'h0;
	localparam logic [3:0]  ADDR_CTRL    = 4'h4;
	localparam logic [31:0] CTRL_RESET   = 32'h0000_0000;
	localparam int          CTRL_SOFT_OFF = 0;
	localparam int          ST_SW_LSB    = 0;
	localparam int          ST_CMD_LSB   = 4;
	localparam int          ST_FAULT     = 8;
	localparam int          ST_REV       = 9;
	localparam int          ST_INRUSH    = 10;
	localparam int          ST_DIE       = 11;
	localparam int          ST_LIMDEF    = 12;
	localparam int          ST_PWRUP     = 13;
	localparam int          ST_REGEN     = 14;
	localparam int          ST_CHOT_LSB  = 16;

	// ------------------------------------------------------------
	// Carriers
	// ------------------------------------------------------------
	typedef struct packed {
		logic       uv_field;
		logic       uv_5v;
		logic       uv_logic;
		logic       die_ot;
		logic       reg_ot;
		logic       lim_open;
		logic       lim_short;
		logic [3:0] chan_ot;
		logic [3:0] reverse_flow_n;
	} supervision_t;

	typedef struct packed {
		logic [3:0]   ctrl;
		logic         hold;
		logic         dis_n;
		logic         inrush_en;
		supervision_t sup;
	} pins_t;

	// Synchroniser reset: supplies read as low and the switches as disabled
	// until real pin levels arrive, so reset cannot fake a good 5V supply.
	localparam pins_t PINS_RESET = pins_t'({4'h0, 1'b0, 1'b0, 1'b0, 3'b111, 12'h000});

endpackage : qsw_pkg

//--- verilog/pin_sync3.sv
// ------------------------------------------------------------
// Three-stage pin synchroniser with agreement filter
// ------------------------------------------------------------
module pin_sync3 #(
	parameter int           W   = 1,
	parameter logic [W-1:0] RST = '0
) (
	input  wire logic         ref_clk,
	input  wire logic         arst_n,
	input  wire logic         ce,
	input  wire logic [W-1:0] pin,
	output logic      [W-1:0] sync
);
	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] agree;

	if (W < 1) begin : g_bad_w
		$error("pin_sync3 needs a width of at least one");
	end

	// A bit moves only once the second and third stages agree.
	assign agree = ~(s2_r ^ s3_r);

	// The first stage is read only by the second one.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			s1_r <= RST;
			s2_r <= RST;
			s3_r <= RST;
			sync <= RST;
		end else if (ce) begin
			s1_r <= pin;
			s2_r <= s1_r;
			s3_r <= s2_r;
			sync <= (agree & s3_r) | (~agree & sync);
		end
	end
endmodule : pin_sync3

//--- verilog/down_timer.sv
// ------------------------------------------------------------
// Retriggerable one-shot down counter
// ------------------------------------------------------------
module down_timer #(
	parameter int          W    = 32,
	parameter logic [31:0] LOAD = 32'h0000_0010
) (
	input  wire logic ref_clk,
	input  wire logic arst_n,
	input  wire logic ce,
	input  wire logic start,
	output logic      busy
);
	logic [W-1:0] cnt_r;

	if (W < 2 || W > 32 || LOAD == 32'h0) begin : g_bad_cfg
		$error("down_timer width or load out of range");
	end

	assign busy = (cnt_r != '0);

	// A new start reloads the full window even while running.
	always_ff @(posedge ref_clk or negedge arst_n) begin
		if (!arst_n) begin
			cnt_r <= '0;
		end else if (ce) begin
			if (start) begin
				cnt_r <= LOAD[W-1:0];
			end else if (busy) begin
				cnt_r <= cnt_r - 1'b1;
			end
		end
	end
endmodule : down_timer

//--- dv/host_model.sv
// ----------------------------------------------------------------
// Host that owns the shared control pins
// ----------------------------------------------------------------
module host_model (
	input  wire logic       ref_clk,
	output logic      [3:0] ctrl_in,
	output logic            hold_select,
	output logic            global_disable_n,
	output logic            inrush_enable
);
	timeunit 1ns;
	timeprecision 1ps;

	// Pins idle with every channel off, transparent and enabled.
	initial begin
		ctrl_in = 4'h0;
		hold_select = 1'b0;
		global_disable_n = 1'b1;
		inrush_enable = 1'b0;
	end

	// values with select
	// All pins move together just after an edge, so a device that is being
	// released from hold never sees another device's control values.
	task automatic drive(input logic [3:0] c, input logic h, input logic d, input logic i);
		@(posedge ref_clk);
		ctrl_in <= c;
		hold_select <= h;
		global_disable_n <= d;
		inrush_enable <= i;
	endtask : drive
endmodule : host_model

//--- dv/quad_switch_protect_ctrl_tb.sv
module quad_switch_protect_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam longint INR = 20;
	localparam longint RTY = 40;
	logic                  ref_clk;
	logic                  arst_n;
	logic [3:0]            ctrl_in;
	logic                  hold_select;
	logic                  global_disable_n;
	logic                  inrush_enable;
	qsw_pkg::supervision_t flags;
	logic [3:0]            addr;
	logic [31:0]           wdata;
	logic                  wr_stb;
	logic                  rd_stb;
	logic [31:0]           rdata;
	logic [3:0]            switch_on;
	logic                  limit_default;
	logic                  limit_double;
	logic                  regulator_enable;
	logic                  fault_o;
	logic                  fault_oe_n;
	logic                  reverse_flow_n_o;
	logic                  reverse_flow_n_oe_n;
	logic [31:0]           rd;
	int                    mismatches;
	int                    compares;
	int                    cycles;

	host_model u_host (.ref_clk(ref_clk), .ctrl_in(ctrl_in), .hold_select(hold_select),
		.global_disable_n(global_disable_n), .inrush_enable(inrush_enable));

	// Short windows keep the run small; the inrush and reverse waits below derive from them.
	quad_switch_protect_ctrl #(.INRUSH_CYC(INR), .RETRY_CYC(RTY)) u_dut (
		.ref_clk(ref_clk), .arst_n(arst_n), .ce(1'b1), .ctrl_in(ctrl_in),
		.hold_select(hold_select), .global_disable_n(global_disable_n),
		.inrush_enable(inrush_enable), .flags(flags), .addr(addr), .wdata(wdata),
		.wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .switch_on(switch_on),
		.limit_default(limit_default), .limit_double(limit_double),
		.regulator_enable(regulator_enable), .fault_o(fault_o), .fault_oe_n(fault_oe_n),
		.reverse_flow_n_o(reverse_flow_n_o), .reverse_flow_n_oe_n(reverse_flow_n_oe_n));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Clock and a hang guard well above the expected run length.
	initial begin
		ref_clk = 1'b0;
		forever #4 ref_clk = ~ref_clk;
	end
	always @(posedge ref_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			conclude();
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, seen);
		end
	endtask : chk
	task automatic cs(input logic [3:0] e);
		chk("switch_on", 32'(switch_on), 32'(e));
	endtask : cs
	task automatic cf(input logic e);
		chk("fault_oe_n", 32'(fault_oe_n), 32'(e));
	endtask : cf
	// Pin paths are levels, so waiting past the sync latency is enough.
	task automatic settle;
		repeat (qsw_pkg::PIN_LAT_CYC + 1) @(posedge ref_clk);
		#1;
	endtask : settle
	task automatic bus_wr(input logic [3:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		addr <= a;
		wdata <= d;
		wr_stb <= 1'b1;
		@(posedge ref_clk);
		wr_stb <= 1'b0;
	endtask : bus_wr
	// Read data is only valid in the cycle after the strobe.
	task automatic bus_rd(input logic [3:0] a);
		@(posedge ref_clk);
		addr <= a;
		rd_stb <= 1'b1;
		@(posedge ref_clk);
		rd_stb <= 1'b0;
		#1;
		rd = rdata;
	endtask : bus_rd
	// Exact latency of one pin change: old value one cycle short, new on time.
	task automatic lat(input logic [3:0] c, input logic h, input logic [3:0] o);
		u_host.drive(c, h, 1'b1, 1'b0);
		repeat (qsw_pkg::PIN_LAT_CYC - 1) @(posedge ref_clk);
		#1;
		cs(o);
		@(posedge ref_clk);
		#1;
	endtask : lat

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	task automatic t_powerup;
		settle();
		cf(1'b0);
		cs(4'h0);
		@(posedge ref_clk);
		flags.uv_5v <= 1'b0;
		settle();
		cf(1'b1);
		chk("fault_o", 32'(fault_o), 32'h0);
		chk("regulator_enable", 32'(regulator_enable), 32'h1);
	endtask : t_powerup

	task automatic t_latch;
		lat(4'h5, 1'b0, 4'h0);
		cs(4'h5);
		lat(4'h5, 1'b1, 4'h5);
		u_host.drive(4'ha, 1'b1, 1'b1, 1'b0);
		settle();
		cs(4'h5);
		lat(4'ha, 1'b0, 4'h5);
		cs(4'ha);
	endtask : t_latch

	task automatic t_disable;
		u_host.drive(4'ha, 1'b0, 1'b0, 1'b0);
		settle();
		cs(4'h0);
		u_host.drive(4'ha, 1'b0, 1'b1, 1'b0);
		settle();
		cs(4'ha);
	endtask : t_disable

	// Walks the three supplies; only the 5V one counts as a fault.
	task automatic t_supply;
		for (int i = 0; i < 3; i++) begin
			@(posedge ref_clk);
			flags[14-i] <= 1'b1;
			settle();
			cs(4'h0);
			if (i == 1) cf(1'b0);
			@(posedge ref_clk);
			flags[14-i] <= 1'b0;
			settle();
			cs(4'ha);
		end
	endtask : t_supply

	task automatic t_limit;
		@(posedge ref_clk);
		flags.lim_open <= 1'b1;
		settle();
		chk("limit_default", 32'(limit_default), 32'h1);
		cs(4'ha);
		@(posedge ref_clk);
		flags.lim_open <= 1'b0;
		flags.lim_short <= 1'b1;
		settle();
		chk("limit_default", 32'(limit_default), 32'h0);
		cs(4'h0);
		cf(1'b0);
		@(posedge ref_clk);
		flags.lim_short <= 1'b0;
		settle();
		cs(4'ha);
		cf(1'b1);
	endtask : t_limit

	task automatic t_thermal;
		@(posedge ref_clk);
		flags.chan_ot <= 4'h1;
		settle();
		cf(1'b1);
		@(posedge ref_clk);
		flags.chan_ot <= 4'h2;
		settle();
		cs(4'h8);
		cf(1'b0);
		@(posedge ref_clk);
		flags.chan_ot <= 4'h0;
		flags.die_ot <= 1'b1;
		settle();
		cs(4'h0);
		cf(1'b0);
		@(posedge ref_clk);
		flags.die_ot <= 1'b0;
		flags.reg_ot <= 1'b1;
		settle();
		chk("regulator_enable", 32'(regulator_enable), 32'h0);
		cf(1'b0);
		@(posedge ref_clk);
		flags.reg_ot <= 1'b0;
		settle();
		chk("regulator_enable", 32'(regulator_enable), 32'h1);
		cs(4'ha);
		cf(1'b1);
	endtask : t_thermal

	// Reverse on a commanded channel, then on an idle one.
	task automatic t_reverse(input logic [3:0] r, input logic f);
		@(posedge ref_clk);
		flags.reverse_flow_n <= r;
		settle();
		chk("reverse_flow_n_oe_n", 32'(reverse_flow_n_oe_n), 32'h0);
		chk("reverse_flow_n_o", 32'(reverse_flow_n_o), 32'h0);
		cs(4'h0);
		cf(f);
		@(posedge ref_clk);
		flags.reverse_flow_n <= 4'h0;
		repeat (RTY / 2) @(posedge ref_clk);
		#1;
		cs(4'h0);
		repeat (RTY) @(posedge ref_clk);
		#1;
		cs(4'ha);
		chk("reverse_flow_n_oe_n", 32'(reverse_flow_n_oe_n), 32'h1);
	endtask : t_reverse

	task automatic t_inrush(input logic en);
		u_host.drive(4'h0, 1'b0, 1'b1, en);
		settle();
		u_host.drive(4'h1, 1'b0, 1'b1, en);
		settle();
		repeat (2) @(posedge ref_clk);
		#1;
		chk("limit_double", 32'(limit_double), 32'(en));
		repeat (INR + 2) @(posedge ref_clk);
		#1;
		chk("limit_double", 32'(limit_double), 32'h0);
		u_host.drive(4'ha, 1'b0, 1'b1, 1'b0);
		settle();
	endtask : t_inrush

	task automatic t_regs;
		bus_rd(qsw_pkg::ADDR_CTRL);
		chk("ctrl", rd, qsw_pkg::CTRL_RESET);
		bus_rd(qsw_pkg::ADDR_STATUS);
		chk("status", rd, 32'h0000_40aa);
		bus_wr(qsw_pkg::ADDR_CTRL, 32'hffff_ffff);
		bus_wr(qsw_pkg::ADDR_STATUS, 32'hffff_ffff);
		settle();
		cs(4'h0);
		bus_rd(qsw_pkg::ADDR_CTRL);
		chk("ctrl", rd, 32'h1);
		bus_rd(qsw_pkg::ADDR_STATUS);
		chk("status", rd, 32'h0000_40a0);
		bus_rd(4'hc);
		chk("unmapped", rd, 32'h0);
		bus_wr(qsw_pkg::ADDR_CTRL, 32'h0);
		settle();
		cs(4'ha);
	endtask : t_regs

	task automatic conclude;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : conclude

	// The 5V supply starts low so the power-up hold can be seen.
	initial begin
		arst_n = 1'b0;
		flags = '0;
		flags.uv_5v = 1'b1;
		addr = 4'h0;
		wdata = 32'h0;
		wr_stb = 1'b0;
		rd_stb = 1'b0;
		repeat (4) @(posedge ref_clk);
		arst_n <= 1'b1;
		t_powerup();
		t_latch();
		t_disable();
		t_supply();
		t_limit();
		t_thermal();
		t_reverse(4'h2, 1'b0);
		t_reverse(4'h1, 1'b1);
		t_inrush(1'b1);
		t_inrush(1'b0);
		t_regs();
		conclude();
	end
endmodule : quad_switch_protect_ctrl_tb
